// ### dual_down_counter_timer.sv
// The implementer's own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/100ps
`include "dual_timer_cfg.svh"
module dual_down_counter_timer
(
   // clock and reset
   input wire logic SYS_CLK_I,
   input wire logic NRST_I,
   // write address channel
   input wire dual_timer_pkg::addr_t AWADDR_I,
   input wire logic AWVALID_I,
   output logic AWREADY_O,
   // write data channel
   input wire dual_timer_pkg::word_t WDATA_I,
   input wire logic [3:0] WSTRB_I,
   input wire logic WVALID_I,
   output logic WREADY_O,
   // write response channel
   output logic [1:0] BRESP_O,
   output logic BVALID_O,
   input wire logic BREADY_I,
   // read address channel
   input wire dual_timer_pkg::addr_t ARADDR_I,
   input wire logic ARVALID_I,
   output logic ARREADY_O,
   // read data channel
   output dual_timer_pkg::word_t RDATA_O,
   output logic [1:0] RRESP_O,
   output logic RVALID_O,
   input wire logic RREADY_I,
   // tick qualifiers, same-clock logic
   input wire logic COUNTER1_TICK_QUALIFIER_I,
   input wire logic COUNTER2_TICK_QUALIFIER_I,
   // interrupts
   output logic COUNTER1_IRQ_O,
   output logic COUNTER2_IRQ_O,
   output logic COMBINED_TIMER_IRQ_O
);
   import dual_timer_pkg::*;

   state_s q; // registered state
   state_s d; // next state
   logic [1:0] qual; // tick qualifier per counter
   logic [1:0] step; // counter decrements or takes its zero event this edge
   logic [1:0] borrow; // decrement passes zero this edge
   logic [1:0][32:0] dec; // decremented count per counter, borrow on top
   logic commit; // buffered write performed now
   logic wsel; // counter addressed by the write
   logic [4:0] woff; // register offset of the write
   logic wmap; // write address is mapped
   logic [1:0] irq; // masked interrupts

   // byte-lane merge of write data
   function automatic word_t merge(input word_t old, input word_t nw, input logic [3:0] s);
      word_t r;
      r = old;
      for (int b = 0; b < 4; b++)
      begin
         if (s[b])
         begin
            r[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return r;
   endfunction

   // one decrement; top bit is the borrow out of the counting width
   function automatic logic [32:0] dec_step(input word_t c, input logic wide);
      logic [32:0] f;
      logic [16:0] h;
      f = {1'b0, c} - 33'h1;
      h = {1'b0, c[15:0]} - 17'h1;
      if (wide)
      begin
         return f;
      end
      return {h[16], c[31:16], h[15:0]};
   endfunction

   // prescaler terminal count for the selected ratio
   function automatic logic pre_hit(input logic [7:0] p, input logic [1:0] sel);
      case (sel)
         `PRE_DIV16: return p[3:0] == 4'hf;
         `PRE_DIV256: return p == 8'hff;
         default: return 1'b1;
      endcase
   endfunction

   // offset is one of the seven registers and the window is in range
   function automatic logic reg_ok(input addr_t a);
      logic r;
      r = 1'b0;
      if (a[11:6] == 6'h00)
      begin
         case (a[4:0])
            `OFS_LOAD, `OFS_VALUE, `OFS_CONTROL, `OFS_INTCLR,
            `OFS_RIS, `OFS_MIS, `OFS_BGLOAD: r = 1'b1;
            default: r = 1'b0;
         endcase
      end
      return r;
   endfunction

   // read mux over one counter's registers
   function automatic word_t rd_mux(input down_counter_unit_s u, input logic [4:0] o);
      case (o)
         `OFS_LOAD, `OFS_BGLOAD: return u.load;
         `OFS_VALUE: return u.count;
         `OFS_CONTROL: return {24'h000000, u.ctrl};
         `OFS_RIS: return {31'h00000000, u.raw};
         `OFS_MIS: return {31'h00000000, u.raw & u.ctrl[`CTL_IE]};
         default: return 32'h00000000;
      endcase
   endfunction

   assign qual = {COUNTER2_TICK_QUALIFIER_I, COUNTER1_TICK_QUALIFIER_I};
   assign commit = (q.ws == WS_COLLECT) && q.aw_full && q.w_full;
   assign wsel = q.aw_addr[`TMR_SEL_BIT];
   assign woff = q.aw_addr[4:0];
   assign wmap = reg_ok(q.aw_addr);

   // per-counter decrement condition and borrow
   always_comb
   begin
      for (int i = 0; i < 2; i++)
      begin
         step[i] = qual[i] && !q.unit[i].pend && q.unit[i].ctrl[`CTL_EN]
                   && pre_hit(q.unit[i].pre, q.unit[i].ctrl[`CTL_PRE_HI:`CTL_PRE_LO])
                   && !q.unit[i].stopped;
         dec[i] = dec_step(q.unit[i].count, q.unit[i].ctrl[`CTL_SIZE32]);
         borrow[i] = dec[i][32];
      end
   end

   // next state: bus channels, counters, register writes
   always_comb
   begin
      word_t nv;
      nv = 32'h00000000;
      d = q;
      // collect address and data in either order
      if (q.ws == WS_COLLECT)
      begin
         if (AWVALID_I && !q.aw_full)
         begin
            d.aw_full = 1'b1;
            d.aw_addr = AWADDR_I;
         end
         if (WVALID_I && !q.w_full)
         begin
            d.w_full = 1'b1;
            d.w_data = WDATA_I;
            d.w_strb = WSTRB_I;
         end
      end
      // response handshake
      if (q.ws == WS_RESP && BREADY_I)
      begin
         d.ws = WS_COLLECT;
      end
      // both halves held: perform the write
      if (commit)
      begin
         d.ws = WS_RESP;
         d.aw_full = 1'b0;
         d.w_full = 1'b0;
         d.bresp = wmap ? `RESP_OKAY : `RESP_SLVERR;
      end
      // counters
      for (int i = 0; i < 2; i++)
      begin
         // clear first so a same-edge zero wins
         if (commit && wmap && wsel == i[0] && woff == `OFS_INTCLR)
         begin
            d.unit[i].raw = 1'b0;
         end
         // qualified edge
         if (qual[i])
         begin
            if (q.unit[i].pend)
            begin
               d.unit[i].count = q.unit[i].pend_val;
               d.unit[i].pend = 1'b0;
               d.unit[i].pre = 8'h00;
            end
            else if (q.unit[i].ctrl[`CTL_EN])
            begin
               d.unit[i].pre = q.unit[i].pre + 8'h01;
            end
         end
         // decrement or zero event
         if (step[i])
         begin
            if (borrow[i])
            begin
               d.unit[i].raw = 1'b1;
               if (q.unit[i].ctrl[`CTL_ONESHOT])
               begin
                  d.unit[i].stopped = 1'b1;
               end
               else if (q.unit[i].ctrl[`CTL_PERIODIC])
               begin
                  d.unit[i].count = q.unit[i].load;
               end
               else
               begin
                  d.unit[i].count = dec[i][31:0];
               end
            end
            else
            begin
               d.unit[i].count = dec[i][31:0];
            end
         end
         // register writes after the count update
         if (commit && wmap && wsel == i[0])
         begin
            case (woff)
               `OFS_LOAD:
               begin
                  nv = merge(q.unit[i].load, q.w_data, q.w_strb);
                  d.unit[i].load = nv;
                  d.unit[i].pend_val = nv;
                  d.unit[i].pend = 1'b1;
                  d.unit[i].stopped = 1'b0;
               end
               `OFS_BGLOAD:
               begin
                  d.unit[i].load = merge(q.unit[i].load, q.w_data, q.w_strb);
               end
               `OFS_CONTROL:
               begin
                  nv = merge({24'h000000, q.unit[i].ctrl}, q.w_data, q.w_strb);
                  d.unit[i].ctrl = nv[7:0];
                  if (!nv[`CTL_ONESHOT])
                  begin
                     d.unit[i].stopped = 1'b0;
                  end
               end
               default:
               begin
                  d.unit[i].stopped = d.unit[i].stopped; // read-only or clear slot
               end
            endcase
         end
      end
      // read channel
      case (q.rs)
         RS_IDLE:
         begin
            if (ARVALID_I)
            begin
               d.rs = RS_DATA;
               d.rdata = reg_ok(ARADDR_I) ? rd_mux(q.unit[ARADDR_I[`TMR_SEL_BIT]], ARADDR_I[4:0])
                                          : 32'h00000000;
               d.rresp = reg_ok(ARADDR_I) ? `RESP_OKAY : `RESP_SLVERR;
            end
         end
         RS_DATA:
         begin
            if (RREADY_I)
            begin
               d.rs = RS_IDLE;
            end
         end
         default:
         begin
            d.rs = RS_IDLE;
         end
      endcase
   end

   // state register, synchronous reset
   always_ff @(posedge SYS_CLK_I)
   begin
      if (!NRST_I)
      begin
         q <= '0;
         for (int i = 0; i < 2; i++)
         begin
            q.unit[i].ctrl <= `CTL_RST;
            q.unit[i].load <= `LOAD_RST;
            q.unit[i].count <= `VALUE_RST;
         end
      end
      else
      begin
         q <= d;
      end
   end

   // masked interrupts and bus outputs
   always_comb
   begin
      for (int i = 0; i < 2; i++)
      begin
         irq[i] = q.unit[i].raw & q.unit[i].ctrl[`CTL_IE];
      end
   end
   assign COUNTER1_IRQ_O = irq[0];
   assign COUNTER2_IRQ_O = irq[1];
   assign COMBINED_TIMER_IRQ_O = irq[0] | irq[1];
   assign AWREADY_O = (q.ws == WS_COLLECT) && !q.aw_full;
   assign WREADY_O = (q.ws == WS_COLLECT) && !q.w_full;
   assign BVALID_O = (q.ws == WS_RESP);
   assign BRESP_O = q.bresp;
   assign ARREADY_O = (q.rs == RS_IDLE);
   assign RVALID_O = (q.rs == RS_DATA);
   assign RDATA_O = q.rdata;
   assign RRESP_O = q.rresp;

   // checks on counter 1 and the bus
   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (!NRST_I);

   sequence s_zero_step;
      step[0] && borrow[0];
   endsequence
   sequence s_value_read;
      ARVALID_I && ARREADY_O && reg_ok(ARADDR_I) && !ARADDR_I[`TMR_SEL_BIT]
      && ARADDR_I[4:0] == `OFS_VALUE;
   endsequence

   AST_COMBINED: assert property (COMBINED_TIMER_IRQ_O == (COUNTER1_IRQ_O | COUNTER2_IRQ_O))
      else $error("combined interrupt is not the OR of both");
   AST_MASK: assert property ((q.unit[0].raw && !q.unit[0].ctrl[`CTL_IE]) |-> !COUNTER1_IRQ_O
                             ##1 (q.unit[0].raw || $past(commit)))
      else $error("mask disturbed the output or the raw flag");
   AST_NO_QUAL: assert property (!qual[0] |=> $stable(q.unit[0].count))
      else $error("count moved without its qualifier");
   AST_DISABLED: assert property ((!q.unit[0].ctrl[`CTL_EN] && !q.unit[0].pend) |=> $stable(q.unit[0].count))
      else $error("disabled counter changed");
   AST_LOAD: assert property ((qual[0] && q.unit[0].pend) |=> q.unit[0].count == $past(q.unit[0].pend_val))
      else $error("load value not applied on qualified edge");
   AST_FREE_WRAP: assert property ((s_zero_step and (!q.unit[0].ctrl[`CTL_ONESHOT] && !q.unit[0].ctrl[`CTL_PERIODIC]
                                   && q.unit[0].ctrl[`CTL_SIZE32])) |=> q.unit[0].count == 32'hffffffff)
      else $error("free-running counter did not wrap to maximum");
   AST_PERIODIC: assert property ((s_zero_step and (!q.unit[0].ctrl[`CTL_ONESHOT] && q.unit[0].ctrl[`CTL_PERIODIC]))
                                  |=> q.unit[0].count == $past(q.unit[0].load))
      else $error("periodic counter did not reload");
   AST_ONESHOT: assert property ((s_zero_step and q.unit[0].ctrl[`CTL_ONESHOT])
                                 |=> q.unit[0].stopped && q.unit[0].raw)
      else $error("one-shot counter did not stop with its flag");
   AST_RAW_HOLD: assert property ((q.unit[0].raw && !(commit && !wsel && woff == `OFS_INTCLR))
                                  |=> q.unit[0].raw)
      else $error("raw flag dropped without a clear write");
   AST_RESUME: assert property ((q.unit[0].stopped && commit && wmap && !wsel
                                 && woff == `OFS_CONTROL && q.w_strb[0]
                                 && !q.w_data[`CTL_ONESHOT]) |=> !q.unit[0].stopped)
      else $error("clearing one-shot did not resume");
   AST_VALUE_READ: assert property (s_value_read |=> RVALID_O && RDATA_O == $past(q.unit[0].count))
      else $error("value read returned the wrong count");
endmodule // dual_down_counter_timer

// ### dual_down_counter_timer_tb_top.sv
`timescale 1ns/100ps
`include "dual_timer_cfg.svh"
// bus master, tick source and checks
module dual_down_counter_timer_tb_top;
   import dual_timer_pkg::*;
   logic clk = 1'b0; // bus clock
   logic rst_n = 1'b0; // reset, active low
   addr_t awaddr = '0, araddr = '0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   word_t wdata = '0, rdata;
   logic [3:0] wstrb = 4'hf;
   logic awready, wready, bvalid, arready, rvalid, irq1, irq2, irqc, tk1, tk2;
   logic [1:0] bresp, rresp;
   logic [1:0] hold = 2'h0; // qualifier hold
   logic sparse = 1'b0; // slow ticks
   int n_errors = 0, check_count = 0, cyc = 0;
   logic [31:0] seed = 32'd46; // lfsr state
   // clock
   always #50 clk = ~clk;
   dual_down_counter_timer dual_down_counter_timer_i (.SYS_CLK_I(clk), .NRST_I(rst_n),
      .AWADDR_I(awaddr), .AWVALID_I(awvalid), .AWREADY_O(awready), .WDATA_I(wdata),
      .WSTRB_I(wstrb), .WVALID_I(wvalid), .WREADY_O(wready), .BRESP_O(bresp),
      .BVALID_O(bvalid), .BREADY_I(bready), .ARADDR_I(araddr), .ARVALID_I(arvalid),
      .ARREADY_O(arready), .RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rvalid),
      .RREADY_I(rready), .COUNTER1_TICK_QUALIFIER_I(tk1), .COUNTER2_TICK_QUALIFIER_I(tk2),
      .COUNTER1_IRQ_O(irq1), .COUNTER2_IRQ_O(irq2), .COMBINED_TIMER_IRQ_O(irqc));
   tick_source tick_source_i (.clk_i(clk), .hold_i(hold), .sparse_i(sparse),
      .tick1_o(tk1), .tick2_o(tk2));
   // random source
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // compare and count
   task automatic chk(input string nm, input word_t e, input word_t g);
      check_count++;
      if (g !== e)
      begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   // verdict and stop
   task automatic complete_run;
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // write: address and data offered together, held until taken
   task automatic wr(input addr_t a, input word_t dat, output logic [1:0] r);
      logic aw_t, w_t, b_t;
      int n;
      aw_t = 1'b0;
      w_t = 1'b0;
      b_t = 1'b0;
      n = 0;
      @(posedge clk);
      awaddr <= a;
      wdata <= dat;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!b_t && n < 100)
      begin
         @(negedge clk);
         aw_t = aw_t | (awvalid & awready);
         w_t = w_t | (wvalid & wready);
         b_t = bvalid;
         r = bresp;
         @(posedge clk);
         if (aw_t) awvalid <= 1'b0;
         if (w_t) wvalid <= 1'b0;
         n++;
      end
      bready <= 1'b0;
      if (!b_t) n_errors++;
   endtask
   // read: address held until taken, data taken with rvalid
   task automatic rd(input addr_t a, output word_t d, output logic [1:0] r);
      logic ar_t, got;
      int n;
      ar_t = 1'b0;
      got = 1'b0;
      n = 0;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!got && n < 100)
      begin
         @(negedge clk);
         ar_t = ar_t | (arvalid & arready);
         got = rvalid;
         d = rdata;
         r = rresp;
         @(posedge clk);
         if (ar_t) arvalid <= 1'b0;
         n++;
      end
      rready <= 1'b0;
      if (!got) n_errors++;
   endtask
   // read and compare with okay response
   task automatic rdchk(input string nm, input addr_t a, input word_t e);
      word_t d;
      logic [1:0] r;
      rd(a, d, r);
      chk(nm, e, d);
      chk("response", {30'h0, `RESP_OKAY}, {30'h0, r});
   endtask
   // bounded wait for a counter's interrupt
   task automatic wait_irq(input int u);
      int n;
      n = 0;
      @(negedge clk);
      while ((u ? irq2 : irq1) !== 1'b1 && n < 200)
      begin
         @(negedge clk);
         n++;
      end
      chk("irq", 32'h1, {31'h0, u ? irq2 : irq1});
   endtask
   // hang guard
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 6000)
      begin
         n_errors++;
         complete_run;
      end
   end
   // main sequence
   initial
   begin
      addr_t b;
      word_t d, ld, ld2;
      logic [1:0] r;
      logic ok;
      int u, s;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      for (u = 0; u < 2; u++)
      begin
         b = u ? 12'h020 : 12'h000;
         rdchk("control", b + `OFS_CONTROL, 32'h20);
         rdchk("load", b + `OFS_LOAD, 32'h0);
         rdchk("value", b + `OFS_VALUE, 32'hffffffff);
         rdchk("raw", b + `OFS_RIS, 32'h0);
      end
      rd(12'h040, d, r);
      chk("unmapped", {30'h0, `RESP_SLVERR}, {30'h0, r});
      chk("unmapped data", 32'h0, d);
      wr(12'h01c, 32'h5, r);
      chk("unmapped write", {30'h0, `RESP_SLVERR}, {30'h0, r});
      $display("test reset and map done");
      // periodic with background reload, both counters, slow ticks on the second
      for (u = 0; u < 2; u++)
      begin
         b = u ? 12'h020 : 12'h000;
         seed = lfsr(seed);
         ld = {29'h0, seed[2:0]} + 32'd20;
         ld2 = {26'h0, seed[8:3]} + 32'h40;
         sparse <= u[0];
         wr(b + `OFS_LOAD, ld, r);
         chk("write response", {30'h0, `RESP_OKAY}, {30'h0, r});
         wr(b + `OFS_CONTROL, 32'he2, r);
         wr(b + `OFS_BGLOAD, ld2, r);
         wait_irq(u);
         chk("combined", 32'h1, {31'h0, irqc});
         rdchk("masked", b + `OFS_MIS, 32'h1);
         wr(b + `OFS_CONTROL, 32'h42, r);
         @(negedge clk);
         chk("masked out", 32'h0, {30'h0, irqc, u ? irq2 : irq1});
         rdchk("raw kept", b + `OFS_RIS, 32'h1);
         rdchk("masked off", b + `OFS_MIS, 32'h0);
         rdchk("reload read", b + `OFS_LOAD, ld2);
         rd(b + `OFS_VALUE, d, r);
         chk("reloaded", 32'h1, {31'h0, d <= ld2 && d + 32'd40 > ld2});
         rdchk("stopped", b + `OFS_VALUE, d);
         wr(b + `OFS_INTCLR, 32'h0, r);
         rdchk("cleared", b + `OFS_RIS, 32'h0);
         $display("test periodic done");
      end
      sparse <= 1'b0;
      // one-shot, resume free, restart by load; 32-bit then 16-bit
      for (s = 1; s >= 0; s--)
      begin
         wr(`OFS_LOAD, 32'h4, r);
         wr(`OFS_CONTROL, {24'h0, 6'h28, s[0], 1'b1}, r);
         wait_irq(0);
         repeat (10) @(posedge clk);
         rdchk("halted", `OFS_VALUE, 32'h0);
         wr(`OFS_INTCLR, 32'h0, r);
         repeat (10) @(posedge clk);
         rdchk("single irq", `OFS_RIS, 32'h0);
         wr(`OFS_CONTROL, {24'h0, 6'h28, s[0], 1'b0}, r);
         rd(`OFS_VALUE, d, r);
         ok = d[31:16] === (s ? 16'hffff : 16'h0) && d[15:8] === 8'hff;
         chk("wrapped", 32'h1, {31'h0, ok});
         seed = lfsr(seed);
         ld = {seed[31:16], 16'h8000};
         wr(`OFS_LOAD, ld, r);
         rd(`OFS_VALUE, d, r);
         chk("restart", 32'h1, {31'h0, d <= ld && d + 32'd20 > ld});
         rdchk("wrap flag", `OFS_RIS, 32'h1);
         wr(`OFS_INTCLR, 32'h0, r);
         $display("test oneshot done");
      end
      // prescale by 16 then by 256 on the second counter
      for (s = 1; s < 3; s++)
      begin
         wr(12'h020 + `OFS_LOAD, 32'd100, r);
         wr(12'h020 + `OFS_CONTROL, {24'h0, 4'h8, s[1:0], 2'h2}, r);
         rdchk("prescaled", 12'h020 + `OFS_VALUE, 32'd100);
         repeat (40) @(posedge clk);
         rd(12'h020 + `OFS_VALUE, d, r);
         ok = (s == 1) ? (d < 32'd100 && d > 32'd96) : (d == 32'd100);
         chk("prescaled later", 32'h1, {31'h0, ok});
      end
      $display("test prescale done");
      // qualifier held low freezes the counter
      hold <= 2'h2;
      rd(12'h020 + `OFS_VALUE, d, r);
      repeat (600) @(posedge clk);
      rdchk("held", 12'h020 + `OFS_VALUE, d);
      hold <= 2'h0;
      $display("test qualifier done");
      // one byte lane of a background load
      wstrb <= 4'h1;
      wr(12'h020 + `OFS_BGLOAD, 32'hffffff5a, r);
      wstrb <= 4'hf;
      rdchk("byte lane", 12'h020 + `OFS_LOAD, 32'h0000005a);
      $display("test strobe done");
      complete_run;
   end
endmodule // dual_down_counter_timer_tb_top

// ### dual_timer_cfg.svh
`ifndef DUAL_TIMER_CFG_SVH
`define DUAL_TIMER_CFG_SVH
// register offsets inside one counter's window
`define OFS_LOAD 5'h00
`define OFS_VALUE 5'h04
`define OFS_CONTROL 5'h08
`define OFS_INTCLR 5'h0c
`define OFS_RIS 5'h10
`define OFS_MIS 5'h14
`define OFS_BGLOAD 5'h18
// address bit that selects the second counter
`define TMR_SEL_BIT 5
// control bit positions
`define CTL_ONESHOT 0
`define CTL_SIZE32 1
`define CTL_PRE_LO 2
`define CTL_PRE_HI 3
`define CTL_IE 5
`define CTL_PERIODIC 6
`define CTL_EN 7
// prescale selections
`define PRE_DIV1 2'h0
`define PRE_DIV16 2'h1
`define PRE_DIV256 2'h2
// reset values
`define CTL_RST 8'h20
`define LOAD_RST 32'h00000000
`define VALUE_RST 32'hffffffff
// bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ### dual_timer_pkg.sv
package dual_timer_pkg;
   // address and data types
   typedef logic [11:0] addr_t;
   typedef logic [31:0] word_t;
   // write channel states
   typedef enum logic [1:0] {WS_COLLECT = 2'b00, WS_RESP = 2'b01} wr_state_e;
   // read channel states
   typedef enum logic {RS_IDLE = 1'b0, RS_DATA = 1'b1} rd_state_e;
   // one down counter with its registers
   typedef struct packed {
      word_t load;
      word_t pend_val;
      logic pend;
      word_t count;
      logic [7:0] ctrl;
      logic raw;
      logic stopped;
      logic [7:0] pre;
   } down_counter_unit_s;
   // whole block state
   typedef struct packed {
      down_counter_unit_s [1:0] unit;
      wr_state_e ws;
      logic aw_full;
      addr_t aw_addr;
      logic w_full;
      word_t w_data;
      logic [3:0] w_strb;
      logic [1:0] bresp;
      rd_state_e rs;
      word_t rdata;
      logic [1:0] rresp;
   } state_s;
endpackage

// ### tick_source.sv
`timescale 1ns/100ps
// far-side tick qualifiers, steady or sparse
module tick_source
(
   // clock and pattern
   input wire logic clk_i,
   input wire logic [1:0] hold_i,
   input wire logic sparse_i,
   // one qualifier per counter
   output logic tick1_o,
   output logic tick2_o
);
   logic [1:0] ph_q = 2'h0; // sparse phase
   // qualifiers change on the bus clock, one per counter
   always_ff @(posedge clk_i)
   begin
      ph_q <= ph_q + 2'h1;
      tick1_o <= ~hold_i[0] & (~sparse_i | (ph_q == 2'h0));
      tick2_o <= ~hold_i[1] & (~sparse_i | (ph_q == 2'h0));
   end
endmodule // tick_source
